// ### verilog/sensor_register_bank.sv
// Register bank of the sensor conditioning device, shared by three serial links.
// Assumes each link decoder hands over whole bytes, one per pulse, synchronous to sys_clk,
// with at least three clock cycles between two bytes of one link.
// Assumes nvs_load pulses once after power-up, before the host starts talking.
`timescale 1ns/10ps

module sensor_register_bank
   import sensor_bank_pkg::*;
#(
   parameter int N_LINKS_P = sensor_bank_pkg::N_LINKS
) (
   input  wire logic                                 sys_clk,
   input  wire logic                                 resetn,
   // Byte streams from the serial link decoders, one lane per link
   input  wire logic [N_LINKS_P-1:0]                 link_frame_start,
   input  wire logic [N_LINKS_P-1:0]                 link_frame_read,
   input  wire logic [N_LINKS_P-1:0]                 link_byte_valid,
   input  wire logic [N_LINKS_P-1:0][7:0]            link_byte_data,
   input  wire logic [N_LINKS_P-1:0]                 link_byte_req,
   output logic      [N_LINKS_P-1:0]                 link_rd_valid,
   output logic      [N_LINKS_P-1:0][7:0]            link_rd_byte,

   // Image read back from nonvolatile storage
   input  wire logic                                 nvs_load,
   input  wire logic [sensor_bank_pkg::W_CFG-1:0]    nvs_configuration,
   input  wire logic [sensor_bank_pkg::W_GAIN-1:0]   nvs_pressure_amp_gain,
   input  wire logic [sensor_bank_pkg::W_CUR-1:0]    nvs_excitation_current_select,
   input  wire logic [sensor_bank_pkg::W_RATE-1:0]   nvs_conversion_rate,
   input  wire logic [sensor_bank_pkg::W_IRQEN-1:0]  nvs_flag_irq_enable,
   input  wire logic [sensor_bank_pkg::W_BRDG-1:0]   nvs_bridge_excitation_select,

   // Anomaly events and converter results
   input  wire logic [sensor_bank_pkg::W_FLAGS-1:0]  anomaly_event,
   input  wire logic                                 pressure_sample_valid,
   input  wire logic [sensor_bank_pkg::W_RAW-1:0]    pressure_sample,
   input  wire logic                                 temperature_sample_valid,
   input  wire logic [sensor_bank_pkg::W_RAW-1:0]    temperature_sample,

   // Register contents for the analog front end
   output logic      [sensor_bank_pkg::W_CFG-1:0]    configuration,
   output logic                                      reference_input_sel,
   output logic      [sensor_bank_pkg::W_GAIN-1:0]   pressure_amp_gain,
   output logic      [sensor_bank_pkg::W_CUR-1:0]    excitation_current_select,
   output logic      [sensor_bank_pkg::W_RATE-1:0]   conversion_rate,
   output logic      [sensor_bank_pkg::W_BRDG-1:0]   bridge_excitation_select,
   output logic      [sensor_bank_pkg::W_FLAGS-1:0]  anomaly_flags,
   output logic                                      alert_n
);
   import sensor_bank_pkg::*;

   // Index width for the write arbiter; one bit even for a single link
   localparam int GW = (N_LINKS_P > 1) ? $clog2(N_LINKS_P) : 1;

   // ==========================================================
   // Register storage
   logic [W_CFG-1:0]   cfg_reg;
   logic               ref_sel_reg;
   logic [W_FLAGS-1:0] flags_reg;
   logic [W_GAIN-1:0]  gain_reg;
   logic [W_CUR-1:0]   cur_reg;
   // Converter results; the bus has no write path to these
   logic [W_RAW-1:0]   raw_p_reg;
   logic [W_RAW-1:0]   raw_t_reg;
   logic [W_RATE-1:0]  rate_reg;
   logic [W_IRQEN-1:0] irqen_reg;
   logic [W_BRDG-1:0]  brdg_reg;
   logic               alert_n_reg;

   // Per-link write requests waiting for the bank
   logic               wr_pend [N_LINKS_P];
   logic [7:0]         wr_addr [N_LINKS_P];
   logic [WORD_W-1:0]  wr_data [N_LINKS_P];
   logic               grant   [N_LINKS_P];

   // ==========================================================
   // Address decode helpers
   // Registers wider than a byte take a two-byte data field
   function automatic logic reg_is_wide(input logic [7:0] a);
      reg_is_wide = (a == ADDR_CONFIGURATION) || (a == ADDR_ANOMALY_FLAGS) ||
                    (a == ADDR_RAW_PRESSURE) || (a == ADDR_RAW_TEMPERATURE) ||
                    (a == ADDR_FLAG_IRQ_ENABLE);
   endfunction

   // Bits above a register's width and unmapped addresses read as zero
   function automatic logic [WORD_W-1:0] read_word(input logic [7:0] a);
      read_word = '0;
      case (a)
         ADDR_CONFIGURATION:   read_word = cfg_reg;
         ADDR_ANOMALY_FLAGS:   read_word = {4'h0, flags_reg};
         ADDR_PRESSURE_GAIN:   read_word = {8'h00, gain_reg};
         ADDR_EXCITATION_CUR:  read_word = {13'h0000, cur_reg};
         ADDR_RAW_PRESSURE:    read_word = raw_p_reg;
         ADDR_RAW_TEMPERATURE: read_word = raw_t_reg;
         ADDR_CONVERSION_RATE: read_word = {12'h000, rate_reg};
         ADDR_FLAG_IRQ_ENABLE: read_word = {6'h00, irqen_reg};
         ADDR_BRIDGE_SELECT:   read_word = {13'h0000, brdg_reg};
         default:              read_word = '0;
      endcase
   endfunction

   // ==========================================================
   // Link front ends, one per serial interface
   genvar gi;
   generate
      for (gi = 0; gi < N_LINKS_P; gi++) begin : g_link
         link_phase_t       phase_reg;
         logic [7:0]        addr_reg;
         logic              idx_reg;
         logic              read_reg;
         logic [7:0]        hold_reg;
         logic              rd_valid_reg;
         logic [7:0]        rd_byte_reg;
         logic [WORD_W-1:0] word;

         // Frame decode; bytes outside the command or data phase fall away
         wire               wide        = reg_is_wide(addr_reg);
         wire               in_data     = (phase_reg == PH_DATA);
         wire               take_cmd    = link_byte_valid[gi] && (phase_reg == PH_CMD);
         wire               take_wr     = link_byte_valid[gi] && in_data && !read_reg;
         wire               serve_rd    = link_byte_req[gi] && in_data && read_reg;
         wire               wr_last     = take_wr && (!wide || idx_reg);
         wire               rd_last     = serve_rd && (!wide || idx_reg);
         // A 16-bit value is captured whole at its first byte so both halves belong together
         wire [7:0]         rd_sel      = !wide ? word[7:0] :
                                          (idx_reg ? hold_reg : word[15:8]);

         // The function reads bank registers a continuous assignment would not
         // wake up on; always_comb follows them as well as the address
         always_comb begin
            word = read_word(addr_reg);
         end

         // Every request gets an answer slot; outside a read data phase it carries 00
         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               rd_valid_reg <= 1'b0;
               rd_byte_reg  <= 8'h00;
            end else begin
               rd_valid_reg <= link_byte_req[gi];
               rd_byte_reg  <= serve_rd ? rd_sel : IDLE_BYTE;
            end
         end

         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               phase_reg    <= PH_IDLE;
               addr_reg     <= 8'h00;
               idx_reg      <= 1'b0;
               read_reg     <= 1'b0;
               hold_reg     <= 8'h00;
            end else begin
               // A new frame restarts the byte count, even in mid-access
               if (link_frame_start[gi]) begin
                  phase_reg <= PH_CMD;
                  read_reg  <= link_frame_read[gi];
                  idx_reg   <= 1'b0;
               end else if (take_cmd) begin
                  addr_reg  <= link_byte_data[gi];
                  phase_reg <= PH_DATA;
                  idx_reg   <= 1'b0;
               end else if (take_wr) begin
                  hold_reg  <= link_byte_data[gi];
                  idx_reg   <= 1'b1;
                  if (wr_last) begin
                     phase_reg <= PH_IDLE;
                  end
               end else if (serve_rd) begin
                  hold_reg  <= word[7:0];
                  idx_reg   <= 1'b1;
                  if (rd_last) begin
                     phase_reg <= PH_IDLE;
                  end
               end
            end
         end

         always_ff @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               wr_pend[gi] <= 1'b0;
               wr_addr[gi] <= 8'h00;
               wr_data[gi] <= 16'h0000;
            end else if (wr_last) begin
               // Park the finished write until the arbiter takes it
               wr_pend[gi] <= 1'b1;
               wr_addr[gi] <= addr_reg;
               wr_data[gi] <= wide ? {hold_reg, link_byte_data[gi]}
                                   : {8'h00, link_byte_data[gi]};
            end else if (grant[gi]) begin
               wr_pend[gi] <= 1'b0;
            end
         end

         // Answer ports come straight from the answer flops
         assign link_rd_valid[gi] = rd_valid_reg;
         assign link_rd_byte[gi]  = rd_byte_reg;
      end
   endgenerate

   // ==========================================================
   // Write arbitration: lowest link index first; a loser waits until no lower link is pending, up to two cycles
   logic          grant_any;
   logic [GW-1:0] grant_idx;

   always_comb begin
      grant_any = 1'b0;
      grant_idx = '0;
      // Scan downward so the lowest pending index is left standing
      for (int k = N_LINKS_P - 1; k >= 0; k--) begin
         if (wr_pend[k]) begin
            grant_any = 1'b1;
            grant_idx = GW'(k);
         end
      end
      for (int k = 0; k < N_LINKS_P; k++) begin
         grant[k] = grant_any && (grant_idx == GW'(k));
      end
   end

   // Only the granted request reaches the bank in a given cycle
   wire [7:0]        wa        = wr_addr[grant_idx];
   wire [WORD_W-1:0] wd        = wr_data[grant_idx];
   wire              hit_cfg   = grant_any && (wa == ADDR_CONFIGURATION);
   wire              hit_flags = grant_any && (wa == ADDR_ANOMALY_FLAGS);
   wire              hit_gain  = grant_any && (wa == ADDR_PRESSURE_GAIN);
   wire              hit_cur   = grant_any && (wa == ADDR_EXCITATION_CUR);
   wire              hit_rate  = grant_any && (wa == ADDR_CONVERSION_RATE);
   wire              hit_irqen = grant_any && (wa == ADDR_FLAG_IRQ_ENABLE);
   wire              hit_brdg  = grant_any && (wa == ADDR_BRIDGE_SELECT);
   // No hit line exists for 06h or 08h, so writes there fall away

   // ==========================================================
   // Next values; the nonvolatile image overrides a write landing in the same cycle
   wire [W_CFG-1:0]   cfg_next   = nvs_load ? nvs_configuration :
                                   hit_cfg  ? wd : cfg_reg;

   // All eight gain bits are kept; codes past the twentieth are not refused
   wire [W_GAIN-1:0]  gain_next  = nvs_load ? nvs_pressure_amp_gain :
                                   hit_gain ? wd[W_GAIN-1:0] : gain_reg;

   wire [W_CUR-1:0]   cur_next   = nvs_load ? nvs_excitation_current_select :
                                   hit_cur  ? wd[W_CUR-1:0] : cur_reg;

   wire [W_RATE-1:0]  rate_next  = nvs_load ? nvs_conversion_rate :
                                   hit_rate ? wd[W_RATE-1:0] : rate_reg;

   wire [W_IRQEN-1:0] irqen_next = nvs_load ? nvs_flag_irq_enable :
                                   hit_irqen ? wd[W_IRQEN-1:0] : irqen_reg;

   wire [W_BRDG-1:0]  brdg_next  = nvs_load ? nvs_bridge_excitation_select :
                                   hit_brdg ? wd[W_BRDG-1:0] : brdg_reg;

   // Writing a one clears a flag; a new event in the same cycle keeps it set
   wire [W_FLAGS-1:0] flag_clr   = hit_flags ? wd[W_FLAGS-1:0] : RST_FLAGS;
   wire [W_FLAGS-1:0] flags_next = (flags_reg & ~flag_clr) | anomaly_event;

   // Flags above the enable width have no enable bit and never drive the alert
   wire               alert_hit  = |(flags_reg[W_IRQEN-1:0] & irqen_reg);

   // ==========================================================
   // Bank registers, split by what feeds them
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_reg     <= RST_CFG;
         ref_sel_reg <= RST_CFG[CFG_REF_SEL_BIT];
      end else begin
         cfg_reg     <= cfg_next;
         ref_sel_reg <= cfg_next[CFG_REF_SEL_BIT];
      end
   end

   // Front-end settings, from the host or the nonvolatile image
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         gain_reg    <= RST_GAIN;
         cur_reg     <= RST_CUR;
         rate_reg    <= RST_RATE;
         irqen_reg   <= RST_IRQEN;
         brdg_reg    <= RST_BRDG;
      end else begin
         gain_reg    <= gain_next;
         cur_reg     <= cur_next;
         rate_reg    <= rate_next;
         irqen_reg   <= irqen_next;
         brdg_reg    <= brdg_next;
      end
   end

   // The alert lags the flags by one cycle so that it leaves a flop
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         flags_reg   <= RST_FLAGS;
         alert_n_reg <= 1'b1;
      end else begin
         flags_reg   <= flags_next;
         alert_n_reg <= ~alert_hit;
      end
   end

   // Result registers follow the converter only; bus writes never reach them
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         raw_p_reg <= RST_RAW;
      end else if (pressure_sample_valid) begin
         raw_p_reg <= pressure_sample;
      end
   end

   // Temperature kept apart so the two channels update independently
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         raw_t_reg <= RST_RAW;
      end else if (temperature_sample_valid) begin
         raw_t_reg <= temperature_sample;
      end
   end

   // Every output leaves a flop; no logic sits behind these
   assign configuration             = cfg_reg;
   assign reference_input_sel       = ref_sel_reg;
   assign pressure_amp_gain         = gain_reg;
   assign excitation_current_select = cur_reg;
   assign conversion_rate           = rate_reg;
   assign bridge_excitation_select  = brdg_reg;
   assign anomaly_flags             = flags_reg;
   assign alert_n                   = alert_n_reg;

endmodule

// ### verilog/sensor_bank_pkg.sv
// Constants shared by the sensor front-end register bank.
// Assumes a byte-level link decoder sits in front of each serial pin group.
package sensor_bank_pkg;

   // ==========================================================
   // Link count and byte geometry
   localparam int N_LINKS  = 3;
   localparam int BYTE_W   = 8;
   localparam int WORD_W   = 16;

   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADDR_CONFIGURATION   = 8'h00;
   localparam logic [7:0] ADDR_ANOMALY_FLAGS   = 8'h02;
   localparam logic [7:0] ADDR_PRESSURE_GAIN   = 8'h04;
   localparam logic [7:0] ADDR_EXCITATION_CUR  = 8'h05;
   localparam logic [7:0] ADDR_RAW_PRESSURE    = 8'h06;
   localparam logic [7:0] ADDR_RAW_TEMPERATURE = 8'h08;
   localparam logic [7:0] ADDR_CONVERSION_RATE = 8'h0A;
   localparam logic [7:0] ADDR_FLAG_IRQ_ENABLE = 8'h0B;
   localparam logic [7:0] ADDR_BRIDGE_SELECT   = 8'h0D;

   // ==========================================================
   // Implemented widths
   localparam int W_CFG   = 16;
   localparam int W_FLAGS = 12;
   localparam int W_GAIN  = 8;
   localparam int W_CUR   = 3;
   localparam int W_RAW   = 16;
   localparam int W_RATE  = 4;
   localparam int W_IRQEN = 10;
   localparam int W_BRDG  = 3;

   // ==========================================================
   // Reset values
   localparam logic [W_CFG-1:0]   RST_CFG   = 16'h0000;
   localparam logic [W_FLAGS-1:0] RST_FLAGS = 12'h000;
   localparam logic [W_GAIN-1:0]  RST_GAIN  = 8'h00;
   localparam logic [W_CUR-1:0]   RST_CUR   = 3'h0;
   localparam logic [W_RAW-1:0]   RST_RAW   = 16'h0000;
   localparam logic [W_RATE-1:0]  RST_RATE  = 4'h0;
   localparam logic [W_IRQEN-1:0] RST_IRQEN = 10'h3FF;
   localparam logic [W_BRDG-1:0]  RST_BRDG  = 3'h0;
   localparam logic [BYTE_W-1:0]  IDLE_BYTE = 8'h00;

   // ==========================================================
   // Field positions
   localparam int CFG_REF_SEL_BIT = 4;

   typedef enum logic [1:0] {PH_IDLE, PH_CMD, PH_DATA} link_phase_t;

endpackage

// ### tb/sensor_bank_chk.sv
// Port-level assertions for the sensor register bank.
// Assumes it is bound to every instance of sensor_register_bank.
`timescale 1ns/10ps
module sensor_bank_chk
   import sensor_bank_pkg::*;
#(
   parameter int N_LINKS_P = 3
) (
   input wire logic                                sys_clk,
   input wire logic                                resetn,
   input wire logic [N_LINKS_P-1:0]                link_byte_valid,
   input wire logic [N_LINKS_P-1:0]                link_byte_req,
   input wire logic [N_LINKS_P-1:0]                link_rd_valid,
   input wire logic [N_LINKS_P-1:0][7:0]           link_rd_byte,
   input wire logic                                nvs_load,
   input wire logic [sensor_bank_pkg::W_CFG-1:0]   nvs_configuration,
   input wire logic [sensor_bank_pkg::W_GAIN-1:0]  nvs_pressure_amp_gain,
   input wire logic [sensor_bank_pkg::W_FLAGS-1:0] anomaly_event,
   input wire logic [sensor_bank_pkg::W_CFG-1:0]   configuration,
   input wire logic                                reference_input_sel,
   input wire logic [sensor_bank_pkg::W_GAIN-1:0]  pressure_amp_gain,
   input wire logic [sensor_bank_pkg::W_FLAGS-1:0] anomaly_flags,
   input wire logic                                alert_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ==========================================================
   // Quiet counter: writes land a few cycles after their last byte
   logic [3:0] quiet_reg;
   logic [3:0] quiet_next;
   assign quiet_next = ((|link_byte_valid) || nvs_load) ? 4'h0 :
                       (quiet_reg == 4'hF) ? quiet_reg : quiet_reg + 4'h1;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) quiet_reg <= 4'h0;
      else quiet_reg <= quiet_next;
   end
   // ==========================================================
   // Properties
   property p_rd_answer; link_rd_valid == $past(link_byte_req); endproperty
   property p_rd_idle; (link_rd_valid == '0) |-> (link_rd_byte == '0); endproperty
   property p_ref_sel; reference_input_sel == configuration[CFG_REF_SEL_BIT]; endproperty
   property p_flag_set;
      (anomaly_event != 12'h000) |=> ((anomaly_flags & $past(anomaly_event)) == $past(anomaly_event));
   endproperty
   property p_nvs_load;
      nvs_load |=> (configuration == $past(nvs_configuration))
                   && (pressure_amp_gain == $past(nvs_pressure_amp_gain));
   endproperty
   property p_hold;
      (quiet_reg >= 4'h6) |-> ($stable(configuration) && $stable(pressure_amp_gain));
   endproperty
   property p_alert_off;
      ($past(anomaly_flags[9:0]) == 10'h000) && (anomaly_flags[9:0] == 10'h000) |-> alert_n;
   endproperty
   property p_alert_on;
      !alert_n |-> ($past(anomaly_flags[9:0]) != 10'h000) || (anomaly_flags[9:0] != 10'h000);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer off its slot");
   a_rd_idle: assert property (p_rd_idle) else $error("read byte not zero when idle");
   a_ref_sel: assert property (p_ref_sel) else $error("reference select wrong");
   a_flag_set: assert property (p_flag_set) else $error("event did not set its flag");
   a_nvs_load: assert property (p_nvs_load) else $error("image not loaded");
   a_hold: assert property (p_hold) else $error("register moved without a write");
   a_alert_off: assert property (p_alert_off) else $error("alert without a flag");
   a_alert_on: assert property (p_alert_on) else $error("alert low without cause");
   c_nvs: cover property (nvs_load);
   c_alert: cover property (!alert_n);
   c_rd_last: cover property (link_rd_valid[N_LINKS_P-1]);
endmodule

bind sensor_register_bank sensor_bank_chk #(.N_LINKS_P(N_LINKS_P)) sensor_bank_chk_inst (
   .sys_clk(sys_clk), .resetn(resetn), .link_byte_valid(link_byte_valid),
   .link_byte_req(link_byte_req), .link_rd_valid(link_rd_valid), .link_rd_byte(link_rd_byte),
   .nvs_load(nvs_load), .nvs_configuration(nvs_configuration),
   .nvs_pressure_amp_gain(nvs_pressure_amp_gain), .anomaly_event(anomaly_event),
   .configuration(configuration), .reference_input_sel(reference_input_sel),
   .pressure_amp_gain(pressure_amp_gain), .anomaly_flags(anomaly_flags), .alert_n(alert_n));

// ### tb/host_link.sv
// Host model for one register link: frames, address and data bytes, read requests.
// Assumes the bank samples every request on the rising edge of sys_clk.
`timescale 1ns/10ps
module host_link (
   input  wire logic       sys_clk,
   output logic            frame_start,
   output logic            frame_read,
   output logic            byte_valid,
   output logic [7:0]      byte_data,
   output logic            byte_req,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_byte
);
   initial begin
      frame_start = 1'b0;
      frame_read  = 1'b0;
      byte_valid  = 1'b0;
      byte_data   = 8'hFF;
      byte_req    = 1'b0;
   end
   task automatic send(input logic [7:0] b);
      repeat (2) @(posedge sys_clk);
      byte_valid <= 1'b1;
      byte_data  <= b;
      @(posedge sys_clk);
      byte_valid <= 1'b0;
      // Idle data shows the inverse so a stale byte cannot pass for a fresh one
      byte_data  <= ~b;
   endtask
   task automatic open(input logic rd);
      @(posedge sys_clk);
      frame_start <= 1'b1;
      frame_read  <= rd;
      @(posedge sys_clk);
      frame_start <= 1'b0;
      frame_read  <= ~rd;
   endtask
   task automatic wr(input logic [7:0] a, input int n, input logic [15:0] d);
      open(1'b0);
      send(a);
      if (n == 2) send(d[15:8]);
      send(d[7:0]);
      // Commit may wait behind two other links
      repeat (6) @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a, input int n, output logic [15:0] q);
      open(1'b1);
      send(a);
      q = 16'h0000;
      for (int k = 0; k < n; k++) begin
         repeat (2) @(posedge sys_clk);
         byte_req <= 1'b1;
         @(posedge sys_clk);
         byte_req <= 1'b0;
         @(posedge sys_clk);
         q = {q[7:0], rd_valid ? rd_byte : 8'hXX};
      end
   endtask
endmodule

// ### tb/tb_sensor_register_bank.sv
// Self-checking bench for the sensor register bank, three host links.
// Assumes host_link models and the bound checker are compiled alongside.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module tb_sensor_register_bank;
   import sensor_bank_pkg::*;
   logic sys_clk, resetn = 1'b0, nvs_load = 1'b0, psv = 1'b0, tsv = 1'b0;
   logic [15:0] nvs_cfg = '0, p_smp = '0, t_smp = '0, q;
   logic [7:0]  nvs_gain = '0;
   logic [2:0]  nvs_cur = '0, nvs_brdg = '0, cur, brdg;
   logic [3:0]  nvs_rate = '0, rate;
   logic [9:0]  nvs_irq = '0;
   logic [11:0] event_bits = '0, anomaly_flags;
   logic [15:0] configuration;
   logic [7:0]  gain;
   logic        reference_input_sel, alert_n;
   wire  [2:0]  fs, fr, bv, br, rv;
   wire  [2:0][7:0] bd, rb;
   int error_cnt = 0, checked = 0;
   logic [7:0]  ta [6] = '{ADDR_CONFIGURATION, ADDR_PRESSURE_GAIN, ADDR_EXCITATION_CUR,
                          ADDR_CONVERSION_RATE, ADDR_BRIDGE_SELECT, ADDR_FLAG_IRQ_ENABLE};
   int          tn [6] = '{2, 1, 1, 1, 1, 2};
   logic [15:0] td [6] = '{16'hA5D3, 16'h007E, 16'h00FF, 16'h00FF, 16'h00FE, 16'hFFFF};
   logic [15:0] te [6] = '{16'hA5D3, 16'h007E, 16'h0007, 16'h000F, 16'h0006, 16'h03FF};
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   for (genvar g = 0; g < 3; g++) begin : g_host
      host_link host_link_inst (.sys_clk(sys_clk), .frame_start(fs[g]), .frame_read(fr[g]),
         .byte_valid(bv[g]), .byte_data(bd[g]), .byte_req(br[g]), .rd_valid(rv[g]),
         .rd_byte(rb[g]));
   end
   sensor_register_bank sensor_register_bank_inst (.sys_clk(sys_clk), .resetn(resetn),
      .link_frame_start(fs), .link_frame_read(fr), .link_byte_valid(bv), .link_byte_data(bd),
      .link_byte_req(br), .link_rd_valid(rv), .link_rd_byte(rb), .nvs_load(nvs_load),
      .nvs_configuration(nvs_cfg), .nvs_pressure_amp_gain(nvs_gain),
      .nvs_excitation_current_select(nvs_cur), .nvs_conversion_rate(nvs_rate),
      .nvs_flag_irq_enable(nvs_irq), .nvs_bridge_excitation_select(nvs_brdg),
      .anomaly_event(event_bits), .pressure_sample_valid(psv), .pressure_sample(p_smp),
      .temperature_sample_valid(tsv), .temperature_sample(t_smp),
      .configuration(configuration), .reference_input_sel(reference_input_sel),
      .pressure_amp_gain(gain), .excitation_current_select(cur), .conversion_rate(rate),
      .bridge_excitation_select(brdg), .anomaly_flags(anomaly_flags), .alert_n(alert_n));
   task automatic wr(input int l, input logic [7:0] a, input int n, input logic [15:0] d);
      case (l)
         0: g_host[0].host_link_inst.wr(a, n, d);
         1: g_host[1].host_link_inst.wr(a, n, d);
         default: g_host[2].host_link_inst.wr(a, n, d);
      endcase
   endtask
   task automatic rd(input int l, input logic [7:0] a, input int n, output logic [15:0] v);
      case (l)
         0: g_host[0].host_link_inst.rd(a, n, v);
         1: g_host[1].host_link_inst.rd(a, n, v);
         default: g_host[2].host_link_inst.rd(a, n, v);
      endcase
   endtask
   task automatic pulse_event(input logic [11:0] e);
      @(posedge sys_clk);
      event_bits <= e;
      @(posedge sys_clk);
      event_bits <= 12'h000;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic wrap_up;
      if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================================
   // Watchdog: the sequence needs well under 3000 cycles
   initial begin
      #50000;
      error_cnt++;
      wrap_up();
   end
   // ==========================================================
   // Main sequence
   initial begin
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      `CHK({configuration, gain, cur, rate, brdg}, 34'h0)
      `CHK(alert_n, 1'b1)
      rd(1, ADDR_FLAG_IRQ_ENABLE, 2, q);
      `CHK(q, RST_IRQEN)
      // Written on one link, read back on the next
      for (int i = 0; i < 6; i++) begin
         wr(i % 3, ta[i], tn[i], td[i]);
         rd((i + 1) % 3, ta[i], tn[i], q);
         `CHK(q, te[i])
      end
      `CHK(reference_input_sel, 1'b1)
      `CHK({cur, rate, brdg}, {3'h7, 4'hF, 3'h6})
      @(posedge sys_clk);
      {psv, tsv, p_smp, t_smp} <= {2'b11, 16'h1234, 16'hBEEF};
      @(posedge sys_clk);
      {psv, tsv} <= 2'b00;
      wr(2, ADDR_RAW_PRESSURE, 2, 16'h5555);
      rd(0, ADDR_RAW_PRESSURE, 2, q);
      `CHK(q, 16'h1234)
      rd(1, ADDR_RAW_TEMPERATURE, 2, q);
      `CHK(q, 16'hBEEF)
      pulse_event(12'h008);
      `CHK(anomaly_flags, 12'h008)
      `CHK(alert_n, 1'b0)
      wr(0, ADDR_FLAG_IRQ_ENABLE, 2, 16'h0000);
      `CHK(alert_n, 1'b1)
      wr(1, ADDR_FLAG_IRQ_ENABLE, 2, 16'h03FF);
      wr(2, ADDR_ANOMALY_FLAGS, 2, 16'h0FFF);
      `CHK(anomaly_flags, 12'h000)
      pulse_event(12'h800);
      `CHK(alert_n, 1'b1)
      rd(0, ADDR_ANOMALY_FLAGS, 2, q);
      `CHK(q, 16'h0800)
      // Same link and address again: the read must follow the new flag
      pulse_event(12'h004);
      `CHK(alert_n, 1'b0)
      rd(0, ADDR_ANOMALY_FLAGS, 2, q);
      `CHK(q, 16'h0804)
      // Power cycle: written values are lost until the image is loaded
      {nvs_cfg, nvs_gain, nvs_cur, nvs_rate, nvs_irq, nvs_brdg} <=
         {16'h1357, 8'h24, 3'h5, 4'h9, 10'h2AA, 3'h3};
      resetn <= 1'b0;
      @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      `CHK(configuration, RST_CFG)
      nvs_load <= 1'b1;
      @(posedge sys_clk);
      nvs_load <= 1'b0;
      @(posedge sys_clk);
      `CHK({configuration, gain, cur, rate, brdg}, {16'h1357, 8'h24, 3'h5, 4'h9, 3'h3})
      rd(2, ADDR_FLAG_IRQ_ENABLE, 2, q);
      `CHK(q, 16'h02AA)
      wrap_up();
   end
endmodule
